/* File: core/vic_pkg.sv */
// Functional notes
// R1: Reset vectors to 0x0000; sources from 0x0003 upward, eight bytes apart.
// R2: Equal-level coinciding requests are served lowest order number first, 0 to 20.
// R3: Enable bit 7 cleared blocks every request regardless of individual masks.
// R4: With the gate set, a source requests only when its own mask is set.
// R5: The cleared gate also blocks sources masked in the extended enable registers.
// R6: Enable bit 6 masks the combined SPI done, collision, fault, overrun request.
// R7: Enable bit 5 masks timer 2, raised by low or high overflow.
// R8: Enable bit 4 masks UART0, raised by receive or transmit flag.
// R9: Enable bit 3 masks the timer 1 overflow request.
// R10: Enable bit 2 masks the second external line request.
// R11: Enable bit 1 masks the timer 0 overflow request.
// R12: Enable bit 0 masks the first external line request.
// R13: Enable register is on every page, bit-addressable, cleared at reset.
// R14: Orders 7 up use extended enable and priority registers at tabled bits.
// R15: Reset entry is always enabled and outranks every other source.
// R16: High level preempts low service; high service is never preempted.
// R17: Pending requests are sampled and decoded every clock, one detect cycle.
// R18: Flags set regardless of masks; after return one instruction runs first.
package vic_pkg;
   // Source count and index widths
   localparam int         NUM_SRC      = 21;
   localparam int         SRC_W        = 5;
   localparam int         IE_SRC_CNT   = 7;
   localparam int         EXT_ENABLE_REG1_SRC_CNT = 8;
   localparam int         EXT_ENABLE_REG2_SRC_CNT = 6;
   localparam int         RESERVED_SRC = 17;
   // Register addresses
   localparam logic [7:0] IE_ADDR      = 8'ha8;
   localparam logic [7:0] IP_ADDR      = 8'hb8;
   localparam logic [7:0] EXT_ENABLE_REG1_ADDR    = 8'he6;
   localparam logic [7:0] EXT_ENABLE_REG2_ADDR    = 8'he7;
   localparam logic [7:0] EXT_PRIORITY_REG1_ADDR    = 8'hf6;
   localparam logic [7:0] EXT_PRIORITY_REG2_ADDR    = 8'hf7;
   // Reset values
   localparam logic [7:0] IE_RESET     = 8'h00;
   localparam logic [7:0] IP_RESET     = 8'h80;
   localparam logic [7:0] EXT_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD  = 8'h00;
   // Field positions
   localparam int         GATE_BIT     = 7;
   localparam int         IP_FIXED_BIT = 7;
   // Vectors
   localparam logic [15:0] VEC_RESET   = 16'h0000;
   localparam logic [15:0] VEC_FIRST   = 16'h0003;
   // Service nesting, Gray ordered
   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_LOW  = 2'b01,
      SVC_NEST = 2'b11,
      SVC_HIGH = 2'b10
   } svc_t;
endpackage

/* File: core/irq_pick.sv */
`timescale 1ns/100ps
module irq_pick #(
   parameter int N = 21,
   parameter int W = 5
) (
   // Requests
   input  wire logic [N-1:0] req,
   // Winner
   output logic              found,
   output logic [W-1:0]      idx
);
   logic [N:0]   seen;
   logic [N-1:0] first;

   // Prefix chain marks the lowest set request
   assign seen[0] = 1'b0;
   for (genvar i = 0; i < N; i++) begin : g_chain
      assign seen[i+1] = seen[i] | req[i];
      assign first[i]  = req[i] & ~seen[i];
   end

   // Encode the one-hot winner
   always_comb begin
      idx   = '0;
      found = seen[N];
      for (int k = 0; k < N; k++) begin
         if (first[k]) begin
            idx = idx | W'(k);
         end
      end
   end
endmodule

/* File: core/vectored_interrupt_controller.sv */
`timescale 1ns/100ps
module vectored_interrupt_controller (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_bit_wr,
   input  wire logic [2:0]  sfr_bit_sel,
   input  wire logic        sfr_bit_val,
   output logic      [7:0]  sfr_rd_data,
   // External pins
   input  wire logic        ext_line0,
   input  wire logic        ext_line1,
   // Peripheral pending flags
   input  wire logic        timer0_overflow_flag,
   input  wire logic        timer1_overflow_flag,
   input  wire logic        uart0_rx_flag,
   input  wire logic        uart0_tx_flag,
   input  wire logic        timer2_high_overflow,
   input  wire logic        timer2_low_overflow,
   input  wire logic        spi_done_flag,
   input  wire logic        spi_collision_flag,
   input  wire logic        spi_fault_flag,
   input  wire logic        spi_overrun_flag,
   input  wire logic [13:0] ext_src_flags,
   // Core handshake
   input  wire logic        core_ack,
   input  wire logic        core_reti,
   input  wire logic        instr_done,
   output logic             irq_req,
   output logic      [15:0] irq_vector,
   output logic      [4:0]  irq_src,
   output logic             irq_level
);
   localparam int N = vic_pkg::NUM_SRC;
   localparam logic [15:0] VEC_FIRST_W = vic_pkg::VEC_FIRST;

   logic [7:0]   interrupt_enable_reg;
   logic [7:0]   priority_select_reg;
   logic [7:0]   ext_enable_reg1;
   logic [7:0]   ext_enable_reg2;
   logic [7:0]   ext_priority_reg1;
   logic [7:0]   ext_priority_reg2;
   logic [7:0]   next_ie;
   logic [7:0]   next_ip;
   logic [7:0]   next_ext_enable_reg1;
   logic [7:0]   next_ext_enable_reg2;
   logic [7:0]   next_ext_priority_reg1;
   logic [7:0]   next_ext_priority_reg2;
   logic [7:0]   next_rd;
   logic [1:0]   line0_sync;
   logic [1:0]   line1_sync;
   logic [N-1:0] pending;
   logic [N-1:0] mask_vec;
   logic [N-1:0] prio_vec;
   logic [N-1:0] pending_en;
   logic         global_irq_gate;
   logic         hi_found;
   logic         lo_found;
   logic [4:0]   hi_idx;
   logic [4:0]   lo_idx;
   logic         cand_found;
   logic         cand_high;
   logic [4:0]   cand_idx;
   logic         allowed;
   logic         reti_hold;
   logic         next_hold;
   logic         next_req;
   logic [15:0]  next_vector;
   vic_pkg::svc_t svc;
   vic_pkg::svc_t next_svc;

   // Register writes, whole byte or single bit
   always_comb begin
      next_ie   = interrupt_enable_reg;
      next_ip   = priority_select_reg;
      next_ext_enable_reg1 = ext_enable_reg1;
      next_ext_enable_reg2 = ext_enable_reg2;
      next_ext_priority_reg1 = ext_priority_reg1;
      next_ext_priority_reg2 = ext_priority_reg2;
      if (sfr_wr) begin
         case (sfr_addr)
            vic_pkg::IE_ADDR:   next_ie   = sfr_wdata; // R13
            vic_pkg::IP_ADDR:   next_ip   = sfr_wdata;
            vic_pkg::EXT_ENABLE_REG1_ADDR: next_ext_enable_reg1 = sfr_wdata;
            vic_pkg::EXT_ENABLE_REG2_ADDR: next_ext_enable_reg2 = sfr_wdata;
            vic_pkg::EXT_PRIORITY_REG1_ADDR: next_ext_priority_reg1 = sfr_wdata;
            vic_pkg::EXT_PRIORITY_REG2_ADDR: next_ext_priority_reg2 = sfr_wdata;
            default:            next_ie   = interrupt_enable_reg;
         endcase
      end
      if (sfr_bit_wr) begin
         case (sfr_addr)
            vic_pkg::IE_ADDR: next_ie[sfr_bit_sel] = sfr_bit_val; // R13
            vic_pkg::IP_ADDR: next_ip[sfr_bit_sel] = sfr_bit_val;
            default:          next_ip = next_ip;
         endcase
      end
      next_ip[vic_pkg::IP_FIXED_BIT] = 1'b1; // Unused bit reads one
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      case (sfr_addr)
         vic_pkg::IE_ADDR:   next_rd = interrupt_enable_reg;
         vic_pkg::IP_ADDR:   next_rd = priority_select_reg;
         vic_pkg::EXT_ENABLE_REG1_ADDR: next_rd = ext_enable_reg1;
         vic_pkg::EXT_ENABLE_REG2_ADDR: next_rd = ext_enable_reg2;
         vic_pkg::EXT_PRIORITY_REG1_ADDR: next_rd = ext_priority_reg1;
         vic_pkg::EXT_PRIORITY_REG2_ADDR: next_rd = ext_priority_reg2;
         default:            next_rd = vic_pkg::UNMAPPED_RD;
      endcase
   end

   // Register file, all enables cleared at reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         interrupt_enable_reg <= vic_pkg::IE_RESET; // R13
         priority_select_reg  <= vic_pkg::IP_RESET;
         ext_enable_reg1      <= vic_pkg::EXT_RESET;
         ext_enable_reg2      <= vic_pkg::EXT_RESET;
         ext_priority_reg1    <= vic_pkg::EXT_RESET;
         ext_priority_reg2    <= vic_pkg::EXT_RESET;
         sfr_rd_data          <= vic_pkg::UNMAPPED_RD;
      end else begin
         interrupt_enable_reg <= next_ie;
         priority_select_reg  <= next_ip;
         ext_enable_reg1      <= next_ext_enable_reg1;
         ext_enable_reg2      <= next_ext_enable_reg2;
         ext_priority_reg1    <= next_ext_priority_reg1;
         ext_priority_reg2    <= next_ext_priority_reg2;
         sfr_rd_data          <= next_rd;
      end
   end

   // Pin synchronisers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         line0_sync <= 2'b00;
         line1_sync <= 2'b00;
      end else begin
         line0_sync <= {line0_sync[0], ext_line0};
         line1_sync <= {line1_sync[0], ext_line1};
      end
   end

   // Gather pending flags; they stand whatever the masks hold
   always_comb begin
      pending     = '0; // R18
      pending[0]  = line0_sync[1]; // R12
      pending[1]  = timer0_overflow_flag; // R11
      pending[2]  = line1_sync[1]; // R10
      pending[3]  = timer1_overflow_flag; // R9
      pending[4]  = uart0_rx_flag | uart0_tx_flag; // R8
      pending[5]  = timer2_high_overflow | timer2_low_overflow; // R7
      pending[6]  = spi_done_flag | spi_collision_flag
                  | spi_fault_flag | spi_overrun_flag; // R6
      pending[N-1:vic_pkg::IE_SRC_CNT] = ext_src_flags;
      pending[vic_pkg::RESERVED_SRC] = 1'b0;
   end

   // Masks and levels from base and extended registers
   assign global_irq_gate = interrupt_enable_reg[vic_pkg::GATE_BIT];
   assign mask_vec = {ext_enable_reg2[vic_pkg::EXT_ENABLE_REG2_SRC_CNT-1:0],
                      ext_enable_reg1,
                      interrupt_enable_reg[vic_pkg::IE_SRC_CNT-1:0]}; // R14
   assign prio_vec = {ext_priority_reg2[vic_pkg::EXT_ENABLE_REG2_SRC_CNT-1:0],
                      ext_priority_reg1,
                      priority_select_reg[vic_pkg::IE_SRC_CNT-1:0]}; // R14
   // Gate overrides every mask, mask bit selects each source
   assign pending_en = global_irq_gate ? (pending & mask_vec) : '0; // R3 R4 R5

   // Fixed-order pick per level
   irq_pick #(.N(N), .W(vic_pkg::SRC_W)) u_pick_high (
      .req   (pending_en & prio_vec),
      .found (hi_found),
      .idx   (hi_idx)
   );
   irq_pick #(.N(N), .W(vic_pkg::SRC_W)) u_pick_low (
      .req   (pending_en & ~prio_vec),
      .found (lo_found),
      .idx   (lo_idx)
   );

   // High level wins, then lowest order number
   assign cand_high  = hi_found; // R16
   assign cand_found = hi_found | lo_found;
   assign cand_idx   = hi_found ? hi_idx : lo_idx; // R2
   // Preemption only of low service by high request
   assign allowed = (svc == vic_pkg::SVC_IDLE)
                  | ((svc == vic_pkg::SVC_LOW) & cand_high); // R16

   // Nesting state and post-return hold
   always_comb begin
      next_svc  = svc;
      next_hold = reti_hold;
      if (instr_done) begin
         next_hold = 1'b0;
      end
      if (core_reti) begin
         next_hold = 1'b1; // R18
      end
      case (svc)
         vic_pkg::SVC_IDLE: begin
            if (core_ack && irq_req) begin
               next_svc = irq_level ? vic_pkg::SVC_HIGH : vic_pkg::SVC_LOW;
            end
         end
         vic_pkg::SVC_LOW: begin
            if (core_ack && irq_req && irq_level) begin
               next_svc = vic_pkg::SVC_NEST; // R16
            end else if (core_reti) begin
               next_svc = vic_pkg::SVC_IDLE;
            end
         end
         vic_pkg::SVC_NEST: begin
            if (core_reti) begin
               next_svc = vic_pkg::SVC_LOW;
            end
         end
         vic_pkg::SVC_HIGH: begin
            if (core_reti) begin
               next_svc = vic_pkg::SVC_IDLE;
            end
         end
         default: next_svc = vic_pkg::SVC_IDLE;
      endcase
   end

   // Request decoded afresh every clock
   always_comb begin
      next_req = cand_found & allowed & ~reti_hold
               & ~core_ack & ~core_reti; // R17 R18
      next_vector = VEC_FIRST_W + {8'h00, cand_idx, 3'b000}; // R1
   end

   // Core-facing outputs; reset entry owns the vector at reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         svc        <= vic_pkg::SVC_IDLE;
         reti_hold  <= 1'b0;
         irq_req    <= 1'b0;
         irq_vector <= vic_pkg::VEC_RESET; // R15
         irq_src    <= 5'h00;
         irq_level  <= 1'b0;
      end else begin
         svc        <= next_svc;
         reti_hold  <= next_hold;
         irq_req    <= next_req;
         irq_vector <= next_vector;
         irq_src    <= cand_idx;
         irq_level  <= cand_high;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   logic [N-1:0] below_mask;
   assign below_mask = (N'(1) << irq_src) - N'(1);

   a_gate_blocks_all: assert property ( // R3 R5
      !global_irq_gate |=> !irq_req
   ) else $error("request raised with global gate cleared");
   a_mask_needed: assert property ( // R4 R14
      irq_req |-> $past(mask_vec[cand_idx])
   ) else $error("request from a masked source");
   a_vector_map: assert property ( // R1
      irq_req |-> irq_vector == 16'h0003 + {8'h00, irq_src, 3'b000}
   ) else $error("vector does not match source");
   a_lowest_first: assert property ( // R2
      irq_req |-> ($past(pending_en & (cand_high ? prio_vec : ~prio_vec))
                   & below_mask) == '0
   ) else $error("lower order source skipped");
   a_high_first: assert property ( // R16
      irq_req && !irq_level |-> $past(pending_en & prio_vec) == '0
   ) else $error("low request chosen over high");
   a_high_not_preempted: assert property ( // R16
      svc == vic_pkg::SVC_HIGH || svc == vic_pkg::SVC_NEST |=> !irq_req
   ) else $error("high service preempted");
   a_reti_wait_instr: assert property ( // R18
      core_reti ##1 !instr_done [*2] |-> !irq_req
   ) else $error("request before one instruction after return");
   a_detect_one_cycle: assert property ( // R17
      cand_found && svc == vic_pkg::SVC_IDLE && !reti_hold && !core_ack
      && !core_reti |=> irq_req
   ) else $error("pending request not detected in one cycle");
   a_spi_mask: assert property ( // R6
      irq_req && irq_src == 5'h06 |-> $past(interrupt_enable_reg[6])
   ) else $error("spi request without its mask");
   a_enable_reset: assert property (@(posedge sys_clk) disable iff (1'b0)
      !rst_n |=> interrupt_enable_reg == 8'h00 && !irq_req
                 && irq_vector == 16'h0000 // R13 R15
   ) else $error("enable or vector wrong after reset");

   c_high_preempts: cover property (svc == vic_pkg::SVC_NEST);
   c_tie_low_order: cover property (irq_req && $past($countones(pending_en)) > 1);
   c_reti_rerequest: cover property (core_reti ##[1:10] irq_req);
endmodule

/* File: tb/core_model.sv */
`timescale 1ns/100ps
module core_model (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Pace controls
   input  wire logic serve,
   input  wire logic slow,
   // Controller link
   input  wire logic irq_req,
   output logic      core_ack,
   output logic      core_reti,
   output logic      instr_done
);
   logic [4:0] cnt;
   logic       busy;
   logic       post;

   // Take a request, run a routine, return, then one instruction
   always_ff @(posedge sys_clk) begin
      core_ack   <= 1'b0;
      core_reti  <= 1'b0;
      instr_done <= 1'b0;
      if (!rst_n) begin
         busy <= 1'b0;
         post <= 1'b0;
         cnt  <= 5'h00;
      end else if (busy) begin
         cnt <= cnt - 5'h01;
         if (cnt == 5'h00) begin
            core_reti <= 1'b1;
            busy      <= 1'b0;
            post      <= 1'b1;
            cnt       <= 5'h02;
         end
      end else if (post) begin
         cnt <= cnt - 5'h01;
         if (cnt == 5'h00) begin
            instr_done <= 1'b1;
            post       <= 1'b0;
         end
      end else if (serve && irq_req) begin
         core_ack <= 1'b1;
         busy     <= 1'b1;
         cnt      <= slow ? 5'h0f : 5'h03; // Slow or prompt routine
      end
   end
endmodule

/* File: tb/vectored_interrupt_controller_bench.sv */
`timescale 1ns/100ps
module vectored_interrupt_controller_bench;
   logic sys_clk = 1'b0, rst_n = 1'b0, serve = 1'b0, slow = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rd_data;
   logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
   logic [2:0] sfr_bit_sel = 3'h0;
   logic ext_line0, ext_line1, timer0_overflow_flag, timer1_overflow_flag;
   logic uart0_rx_flag, uart0_tx_flag, timer2_high_overflow;
   logic timer2_low_overflow, spi_done_flag, spi_collision_flag;
   logic spi_fault_flag, spi_overrun_flag;
   logic [13:0] ext_src_flags;
   logic core_ack, core_reti, instr_done, irq_req, irq_level;
   logic after_reti = 1'b0;
   logic [15:0] irq_vector;
   logic [4:0]  irq_src;
   logic [31:0] seed = 32'hfe29;
   int n_errors = 0, n_tests = 0, n_ack = 0, cyc = 0, k, i;

   vectored_interrupt_controller DUT (
      .sys_clk              (sys_clk),
      .rst_n                (rst_n),
      .sfr_addr             (sfr_addr),
      .sfr_wr               (sfr_wr),
      .sfr_wdata            (sfr_wdata),
      .sfr_bit_wr           (sfr_bit_wr),
      .sfr_bit_sel          (sfr_bit_sel),
      .sfr_bit_val          (sfr_bit_val),
      .sfr_rd_data          (sfr_rd_data),
      .ext_line0            (ext_line0),
      .ext_line1            (ext_line1),
      .timer0_overflow_flag (timer0_overflow_flag),
      .timer1_overflow_flag (timer1_overflow_flag),
      .uart0_rx_flag        (uart0_rx_flag),
      .uart0_tx_flag        (uart0_tx_flag),
      .timer2_high_overflow (timer2_high_overflow),
      .timer2_low_overflow  (timer2_low_overflow),
      .spi_done_flag        (spi_done_flag),
      .spi_collision_flag   (spi_collision_flag),
      .spi_fault_flag       (spi_fault_flag),
      .spi_overrun_flag     (spi_overrun_flag),
      .ext_src_flags        (ext_src_flags),
      .core_ack             (core_ack),
      .core_reti            (core_reti),
      .instr_done           (instr_done),
      .irq_req              (irq_req),
      .irq_vector           (irq_vector),
      .irq_src              (irq_src),
      .irq_level            (irq_level)
   );
   core_model partner (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .serve      (serve),
      .slow       (slow),
      .irq_req    (irq_req),
      .core_ack   (core_ack),
      .core_reti  (core_reti),
      .instr_done (instr_done)
   );

   // Clock
   always #50 sys_clk = ~sys_clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] exp_vec(input int s);
      return 16'h0003 + (s[15:0] << 3);
   endfunction

   task automatic check1(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check8(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check16(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      tick(1);
      sfr_wr    = 1'b0;
      tick(1);
   endtask

   task automatic bwr(input logic [2:0] b, input logic v);
      sfr_addr    = 8'ha8;
      sfr_bit_sel = b;
      sfr_bit_val = v;
      sfr_bit_wr  = 1'b1;
      tick(1);
      sfr_bit_wr  = 1'b0;
      tick(1);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      tick(1);
      check8("sfr_rd_data", e, sfr_rd_data);
   endtask

   // Raise one flag of a source, picked at random; clearing drops all
   task automatic raise(input int s, input logic v);
      logic [31:0] r;
      r = xs();
      case (s)
         0: ext_line0 = v;
         1: timer0_overflow_flag = v;
         2: ext_line1 = v;
         3: timer1_overflow_flag = v;
         4: {uart0_rx_flag, uart0_tx_flag} = {v & r[0], v & ~r[0]};
         5: {timer2_high_overflow, timer2_low_overflow} =
               {v & r[0], v & ~r[0]};
         default: {spi_done_flag, spi_collision_flag, spi_fault_flag,
                   spi_overrun_flag} = {4{v}} & (4'h1 << r[1:0]);
      endcase
   endtask

   task automatic clr();
      for (int s = 0; s < 7; s++) raise(s, 1'b0);
      ext_src_flags = 14'h0000;
   endtask

   task automatic conclude();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watch returns, count calls, cut a hang short; settled mid-cycle
   always @(negedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         conclude();
      end
      if (core_ack) n_ack++;
      if (after_reti) check1("irq_req_after_return", 1'b0, irq_req);
      if (!rst_n || instr_done) after_reti = 1'b0;
      else if (core_reti) after_reti = 1'b1;
   end

   initial begin
      clr();
      tick(2);
      check16("irq_vector", 16'h0000, irq_vector);
      rst_n = 1'b1;
      tick(1);
      rdchk(8'ha8, 8'h00);
      k = xs();
      wr(8'ha8, k[7:0]);
      rdchk(8'ha8, k[7:0]);
      rdchk(8'h55, 8'h00);
      for (k = 0; k < 7; k++) begin
         wr(8'ha8, 8'h80 | (8'h01 << k));
         raise(k, 1'b1);
         tick(1);
         if (k != 0 && k != 2) check1("irq_req", 1'b1, irq_req);
         tick(3);
         check1("irq_req", 1'b1, irq_req);
         check16("irq_vector", exp_vec(k), irq_vector);
         check8("irq_src", k[7:0], {3'h0, irq_src});
         wr(8'ha8, 8'h01 << k);
         tick(3);
         check1("irq_req", 1'b0, irq_req);
         wr(8'ha8, ~(8'h01 << k));
         tick(3);
         check1("irq_req", 1'b0, irq_req);
         raise(k, 1'b0);
      end
      wr(8'ha8, 8'h81);
      raise(0, 1'b1);
      bwr(3'h7, 1'b0);
      tick(3);
      check1("irq_req", 1'b0, irq_req);
      bwr(3'h7, 1'b1);
      tick(3);
      check1("irq_req", 1'b1, irq_req);
      wr(8'ha8, 8'hff);
      for (k = 1; k < 7; k++) raise(k, 1'b1);
      tick(3);
      check8("irq_src", 8'h00, {3'h0, irq_src});
      wr(8'hb8, 8'h40);
      tick(3);
      check8("irq_src", 8'h06, {3'h0, irq_src});
      check1("irq_level", 1'b1, irq_level);
      wr(8'hb8, 8'h00);
      clr();
      wr(8'ha8, 8'h80);
      wr(8'he6, 8'h01);
      wr(8'he7, 8'h20);
      ext_src_flags = 14'h2000;
      tick(3);
      check16("irq_vector", exp_vec(20), irq_vector);
      ext_src_flags = 14'h2001;
      tick(3);
      check8("irq_src", 8'h07, {3'h0, irq_src});
      wr(8'ha8, 8'h00);
      tick(3);
      check1("irq_req", 1'b0, irq_req);
      clr();
      wr(8'ha8, 8'h8b);
      wr(8'hb8, 8'h08);
      slow  = 1'b1;
      serve = 1'b1;
      raise(1, 1'b1);
      for (i = 0; i < 20 && !core_ack; i++) tick(1);
      check1("core_ack", 1'b1, core_ack);
      tick(3);
      check1("irq_req", 1'b0, irq_req);
      raise(3, 1'b1);
      tick(3);
      check1("irq_req", 1'b1, irq_req);
      check8("irq_src", 8'h03, {3'h0, irq_src});
      check1("irq_level", 1'b1, irq_level);
      raise(3, 1'b0);
      slow  = 1'b0;
      n_ack = 0;
      tick(60);
      check1("reentry", 1'b1, n_ack >= 2);
      serve = 1'b0;
      clr();
      tick(20);
      conclude();
   end
endmodule
